// ### shared/ifx_pkg.sv
// Constants, reset values and decode helpers for the transmitter control register bank
// Summary of operation
// - Enable bit1 gain stage, bit0 low-pass filter
// - Gain code in bits 14:9, reset zero
// - Gain register unused bits read/write, reset zero
// - Bias register resets to its field defaults
// - Mixer I bit 11 selects image sideband
// - Mixer I polarity bit 8, offset 7:0
// - Mixer Q polarity bit 8, offset 7:0
// - Mixer Q upper bits reset to 1111000
// - I phase trim bits 8:0, upper 1111000
// - Q phase trim bits 8:0, upper 1111000
// - Frame: chip address, register, 16 data bits
// - Load register when select returns high
// - Register 7 pointer selects 48-clock readback
`default_nettype none
package ifx_pkg;
	localparam int REG_W    = 16;
	localparam int NUM_REGS = 10;
	localparam int CHIP_W   = 3;
	localparam int REGNUM_W = 5;

	// Frame lengths in serial clock pulses
	localparam logic [5:0] FRAME_BITS = 6'h18;
	localparam logic [5:0] READ_BITS  = 6'h30;

	// Register numbers
	localparam logic [4:0] ADDR_ENABLE   = 5'h01;
	localparam logic [4:0] ADDR_GAIN     = 5'h03;
	localparam logic [4:0] ADDR_BIAS     = 5'h04;
	localparam logic [4:0] ADDR_MIX_I    = 5'h05;
	localparam logic [4:0] ADDR_MIX_Q    = 5'h06;
	localparam logic [4:0] ADDR_READ_PTR = 5'h07;
	localparam logic [4:0] ADDR_TRIM_I   = 5'h08;
	localparam logic [4:0] ADDR_TRIM_Q   = 5'h09;

	// Field positions
	localparam int GAIN_STAGE_BIT = 1;
	localparam int LPF_BIT        = 0;
	localparam int GAIN_CODE_MSB  = 14;
	localparam int GAIN_CODE_LSB  = 9;
	localparam int CURRENT_MSB    = 8;
	localparam int CURRENT_LSB    = 7;
	localparam int ENV_MSB        = 6;
	localparam int ENV_LSB        = 2;
	localparam int ATT_MSB        = 1;
	localparam int ATT_LSB        = 0;
	localparam int SIDEBAND_BIT   = 11;
	localparam int POLARITY_BIT   = 8;
	localparam int OFFSET_MSB     = 7;
	localparam int TRIM_MSB       = 8;
	localparam int PTR_MSB        = 15;
	localparam int PTR_LSB        = 11;

	// Reset values
	localparam logic [15:0] RST_ENABLE = 16'hD9FA;
	localparam logic [15:0] RST_GAIN   = 16'h0000;
	localparam logic [15:0] RST_BIAS   = 16'h0FF2;
	localparam logic [15:0] RST_MIX_I  = 16'h2A00;
	localparam logic [15:0] RST_MIX_Q  = 16'hF000;
	localparam logic [15:0] RST_PTR    = 16'h0000;
	localparam logic [15:0] RST_TRIM_I = 16'hF000;
	localparam logic [15:0] RST_TRIM_Q = 16'hF000;
	localparam logic [15:0] RST_NONE   = 16'h0000;

	typedef logic [NUM_REGS-1:0][REG_W-1:0] ifx_regs_t;

	localparam ifx_regs_t RST_ALL = {RST_TRIM_Q, RST_TRIM_I, RST_PTR, RST_MIX_Q, RST_MIX_I,
		RST_BIAS, RST_GAIN, RST_NONE, RST_ENABLE, RST_NONE};

	// True for register numbers that hold storage
	function automatic logic reg_mapped(input logic [4:0] num);
		reg_mapped = (num == ADDR_ENABLE) || ((num >= ADDR_GAIN) && (num <= ADDR_TRIM_Q));
	endfunction
endpackage
`default_nettype wire

// ### shared/ifx_ser_if.sv
// Write strobe and readback word between the serial shifter and the register bank
`timescale 1ns/1ns
`default_nettype none
interface ifx_ser_if;
	logic        wr_stb;
	logic [4:0]  wr_reg;
	logic [15:0] wr_data;
	logic [15:0] rd_data;

	modport shifter (
		output wr_stb,
		output wr_reg,
		output wr_data,
		input  rd_data
	);
	modport regs (
		input  wr_stb,
		input  wr_reg,
		input  wr_data,
		output rd_data
	);
endinterface
`default_nettype wire

// ### rtl/ifx_serial_shift.sv
// Three-wire serial frame receiver and readback shifter
`timescale 1ns/1ns
`default_nettype none
module ifx_serial_shift
	import ifx_pkg::*;
#(
	parameter logic [2:0] CHIP_ADDR = 3'h0
) (
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// Serial pins
	input  wire logic      sclk_pin,
	input  wire logic      sel_n_pin,
	input  wire logic      din_pin,
	output logic           serial_out,
	// Register bank side
	ifx_ser_if.shifter     bus
);
	logic [2:0]  sync1_ff;
	logic [2:0]  sync2_ff;
	logic        sclk_d_ff;
	logic        sel_d_ff;
	logic [23:0] shift_ff;
	logic [23:0] nxt_shift;
	logic [5:0]  cnt_ff;
	logic [5:0]  nxt_cnt;
	logic [15:0] rdsh_ff;
	logic [15:0] nxt_rdsh;
	logic        out_ff;
	logic        nxt_out;
	logic        wr_stb_ff;
	logic        nxt_wr_stb;
	logic [4:0]  wr_reg_ff;
	logic [4:0]  nxt_wr_reg;
	logic [15:0] wr_data_ff;
	logic [15:0] nxt_wr_data;
	logic        rise;
	logic        frame_end;

	// Bit 0 clock, bit 1 select, bit 2 data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff  <= 3'h2;
			sync2_ff  <= 3'h2;
			sclk_d_ff <= 1'b0;
			sel_d_ff  <= 1'b1;
		end else begin
			sync1_ff  <= {din_pin, sel_n_pin, sclk_pin};
			sync2_ff  <= sync1_ff;
			sclk_d_ff <= sync2_ff[0];
			sel_d_ff  <= sync2_ff[1];
		end
	end

	assign rise      = sync2_ff[0] & ~sclk_d_ff & ~sync2_ff[1];
	assign frame_end = sync2_ff[1] & ~sel_d_ff;

	always_comb begin
		nxt_shift   = shift_ff;
		nxt_cnt     = cnt_ff;
		nxt_rdsh    = rdsh_ff;
		nxt_out     = out_ff;
		nxt_wr_stb  = 1'b0;
		nxt_wr_reg  = wr_reg_ff;
		nxt_wr_data = wr_data_ff;
		if (sync2_ff[1]) begin
			nxt_cnt  = 6'h00;
			nxt_rdsh = 16'h0000;
			nxt_out  = 1'b0;
		end else if (rise) begin
			nxt_shift = {shift_ff[22:0], sync2_ff[2]};
			if (cnt_ff != READ_BITS) begin
				nxt_cnt = cnt_ff + 6'h01;
			end
			// Readback word starts after the 24th pulse
			if (cnt_ff == FRAME_BITS - 6'h01) begin
				nxt_rdsh = {bus.rd_data[14:0], 1'b0};
				nxt_out  = bus.rd_data[15];
			end else begin
				nxt_rdsh = {rdsh_ff[14:0], 1'b0};
				nxt_out  = rdsh_ff[15];
			end
		end
		// Only an exact 24-pulse frame for this chip loads a register
		if (frame_end && (cnt_ff == FRAME_BITS) && (shift_ff[23:21] == CHIP_ADDR)) begin
			nxt_wr_stb  = 1'b1;
			nxt_wr_reg  = shift_ff[20:16];
			nxt_wr_data = shift_ff[15:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_ff   <= 24'h00_0000;
			cnt_ff     <= 6'h00;
			rdsh_ff    <= 16'h0000;
			out_ff     <= 1'b0;
			wr_stb_ff  <= 1'b0;
			wr_reg_ff  <= 5'h00;
			wr_data_ff <= 16'h0000;
		end else begin
			shift_ff   <= nxt_shift;
			cnt_ff     <= nxt_cnt;
			rdsh_ff    <= nxt_rdsh;
			out_ff     <= nxt_out;
			wr_stb_ff  <= nxt_wr_stb;
			wr_reg_ff  <= nxt_wr_reg;
			wr_data_ff <= nxt_wr_data;
		end
	end

	assign bus.wr_stb  = wr_stb_ff;
	assign bus.wr_reg  = wr_reg_ff;
	assign bus.wr_data = wr_data_ff;
	assign serial_out  = out_ff;

	frame_load_a: assert property (@(posedge clk) disable iff (rst)
		wr_stb_ff |-> ($past(cnt_ff) == FRAME_BITS) && sel_d_ff && !$past(sel_d_ff))
		else $error("register load without a completed 24-pulse frame");

	readback_start_a: assert property (@(posedge clk) disable iff (rst)
		(rise && cnt_ff == FRAME_BITS - 6'h01) |=> (out_ff == $past(bus.rd_data[15])) [*1] ##1 1'b1)
		else $error("readback did not start with the word's top bit");

	frame_shift_a: assert property (@(posedge clk) disable iff (rst)
		rise |=> shift_ff[0] == $past(sync2_ff[2]) && cnt_ff != 6'h00)
		else $error("serial bit not captured on clock rise");
endmodule
`default_nettype wire

// ### rtl/ifx_ctrl_regs.sv
// Control register bank of the transmitter, reached over the three-wire serial port
`timescale 1ns/1ns
`default_nettype none
module ifx_ctrl_regs
	import ifx_pkg::*;
#(
	// Chip address matched in each frame; value is arbitrary
	parameter logic [2:0] CHIP_ADDR = 3'h0
) (
	// Clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RESET,
	// Serial port
	input  wire logic       SERIAL_CLK,
	input  wire logic       SERIAL_SELECT_N,
	input  wire logic       SERIAL_IN,
	output logic            SERIAL_OUT,
	// Enables
	output logic            GAIN_STAGE_ON,
	output logic            LOWPASS_FILTER_ON,
	// Gain stage
	output logic [5:0]      GAIN_CODE,
	output logic [1:0]      AMPLIFIER_CURRENT_SETTING,
	output logic [4:0]      ENVELOPE_LEVEL_SETTING,
	output logic [1:0]      ATTENUATION_BIAS_SETTING,
	// Image reject mixer
	output logic            IMAGE_SIDEBAND_SELECT,
	output logic            IN_PHASE_OFFSET_POLARITY,
	output logic [7:0]      IN_PHASE_OFFSET_VALUE,
	output logic            QUADRATURE_OFFSET_POLARITY,
	output logic [7:0]      QUADRATURE_OFFSET_VALUE,
	// Phase trims
	output logic [8:0]      IN_PHASE_TRIM,
	output logic [8:0]      QUADRATURE_TRIM
);
	ifx_ser_if bus ();

	ifx_regs_t  reg_ff;
	ifx_regs_t  nxt_reg;
	logic [4:0] rd_ptr;

	ifx_serial_shift #(
		.CHIP_ADDR (CHIP_ADDR)
	) u_shift (
		.clk        (REF_CLK),
		.rst        (RESET),
		.sclk_pin   (SERIAL_CLK),
		.sel_n_pin  (SERIAL_SELECT_N),
		.din_pin    (SERIAL_IN),
		.serial_out (SERIAL_OUT),
		.bus        (bus.shifter)
	);

	// Whole words are stored, reserved bits included
	always_comb begin
		nxt_reg = reg_ff;
		if (bus.wr_stb && reg_mapped(bus.wr_reg)) begin
			nxt_reg[bus.wr_reg[3:0]] = bus.wr_data;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			reg_ff <= RST_ALL;
		end else begin
			reg_ff <= nxt_reg;
		end
	end

	// Register 7 points at the word returned by the next read frame
	assign rd_ptr      = reg_ff[ADDR_READ_PTR][PTR_MSB:PTR_LSB];
	assign bus.rd_data = reg_mapped(rd_ptr) ? reg_ff[rd_ptr[3:0]] : 16'h0000;

	assign GAIN_STAGE_ON              = reg_ff[ADDR_ENABLE][GAIN_STAGE_BIT];
	assign LOWPASS_FILTER_ON          = reg_ff[ADDR_ENABLE][LPF_BIT];
	assign GAIN_CODE                  = reg_ff[ADDR_GAIN][GAIN_CODE_MSB:GAIN_CODE_LSB];
	assign AMPLIFIER_CURRENT_SETTING  = reg_ff[ADDR_BIAS][CURRENT_MSB:CURRENT_LSB];
	assign ENVELOPE_LEVEL_SETTING     = reg_ff[ADDR_BIAS][ENV_MSB:ENV_LSB];
	assign ATTENUATION_BIAS_SETTING   = reg_ff[ADDR_BIAS][ATT_MSB:ATT_LSB];
	assign IMAGE_SIDEBAND_SELECT      = reg_ff[ADDR_MIX_I][SIDEBAND_BIT];
	assign IN_PHASE_OFFSET_POLARITY   = reg_ff[ADDR_MIX_I][POLARITY_BIT];
	assign IN_PHASE_OFFSET_VALUE      = reg_ff[ADDR_MIX_I][OFFSET_MSB:0];
	assign QUADRATURE_OFFSET_POLARITY = reg_ff[ADDR_MIX_Q][POLARITY_BIT];
	assign QUADRATURE_OFFSET_VALUE    = reg_ff[ADDR_MIX_Q][OFFSET_MSB:0];
	assign IN_PHASE_TRIM              = reg_ff[ADDR_TRIM_I][TRIM_MSB:0];
	assign QUADRATURE_TRIM            = reg_ff[ADDR_TRIM_Q][TRIM_MSB:0];

	enable_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && bus.wr_reg == ADDR_ENABLE) |=>
			GAIN_STAGE_ON == $past(bus.wr_data[1]) && LOWPASS_FILTER_ON == $past(bus.wr_data[0]))
		else $error("enable bits did not follow the written word");

	gain_code_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && bus.wr_reg == ADDR_GAIN) |=> GAIN_CODE == $past(bus.wr_data[14:9]))
		else $error("gain code did not follow the written word");

	gain_unused_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && bus.wr_reg == ADDR_GAIN) |=>
			{reg_ff[ADDR_GAIN][15], reg_ff[ADDR_GAIN][8:0]} == $past({bus.wr_data[15], bus.wr_data[8:0]}))
		else $error("gain register unused bits not stored");

	reset_values_a: assert property (@(posedge REF_CLK)
		$fell(RESET) |-> reg_ff[ADDR_BIAS] == 16'h0FF2 && reg_ff[ADDR_MIX_Q] == 16'hF000
			&& reg_ff[ADDR_TRIM_I] == 16'hF000 && reg_ff[ADDR_TRIM_Q] == 16'hF000
			&& reg_ff[ADDR_GAIN] == 16'h0000 && reg_ff[ADDR_ENABLE][1:0] == 2'h2)
		else $error("register bank reset value wrong");

	sideband_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && bus.wr_reg == ADDR_MIX_I) |=>
			IMAGE_SIDEBAND_SELECT == $past(bus.wr_data[11]) ##1 $stable(IMAGE_SIDEBAND_SELECT) || bus.wr_stb
			|| $past(bus.wr_stb))
		else $error("sideband select did not follow the written word");

	quad_offset_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && bus.wr_reg == ADDR_MIX_Q) |=>
			{QUADRATURE_OFFSET_POLARITY, QUADRATURE_OFFSET_VALUE} == $past(bus.wr_data[8:0])
			&& reg_ff[ADDR_MIX_Q][15:9] == $past(bus.wr_data[15:9]))
		else $error("quadrature offset not stored");

	unmapped_ignore_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && !reg_mapped(bus.wr_reg)) |=> $stable(reg_ff))
		else $error("write to an empty register number changed the bank");

	readback_sel_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(bus.wr_stb && bus.wr_reg == ADDR_READ_PTR && reg_mapped(bus.wr_data[15:11])) |=>
			bus.rd_data == reg_ff[$past(bus.wr_data[14:11])])
		else $error("readback word does not follow the register 7 pointer");
endmodule
`default_nettype wire

// ### verification/ifx_host_model.sv
// Host controller model driving the three-wire serial port
`timescale 1ns/1ns
`default_nettype none
module ifx_host_model (
	// System clock
	input  wire logic clk,
	// Serial pins
	input  wire logic serial_out,
	output logic      serial_clk,
	output logic      serial_select_n,
	output logic      serial_in
);
	logic [15:0] rd_word;

	initial begin
		serial_clk = 1'b0;
		serial_select_n = 1'b1;
		serial_in = 1'b0;
		rd_word = 16'h0000;
	end

	// Half of a 160 ns serial clock period
	task automatic half();
		repeat (8) @(negedge clk);
	endtask

	// Serial clock stands low outside frames; filler bits toggle
	task automatic frame(input logic [23:0] w, input int n);
		@(negedge clk);
		serial_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in = (i < 24) ? w[23-i] : ~serial_in;
			half();
			if (i >= 24 && i < 40)
				rd_word[39-i] = serial_out;
			serial_clk = 1'b1;
			half();
			serial_clk = 1'b0;
		end
		half();
		serial_select_n = 1'b1;
		serial_in = ~serial_in;
		half();
	endtask

	task automatic write_reg(input logic [2:0] chip, input logic [4:0] num, input logic [15:0] d, input int n);
		frame({chip, num, d}, n);
	endtask

	task automatic read_reg(input logic [4:0] num);
		frame({3'h0, 5'h07, num, 11'h000}, 24);
		frame({3'h0, 5'h07, num, 11'h000}, 48);
	endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking testbench of the transmitter control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ifx_pkg::*;
	logic        clk;
	logic        rst;
	logic        sclk;
	logic        sel_n;
	logic        ser_in;
	logic        ser_out;
	wire  [53:0] fields;
	int          num_errors;
	int          check_count;
	logic [4:0]  adr [7] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09};
	logic [15:0] rst_v [7] = '{16'hD9FA, 16'h0000, 16'h0FF2, 16'h2A00, 16'hF000, 16'hF000, 16'hF000};
	logic [15:0] pat_v [7] = '{16'h2601, 16'hC7FF, 16'hF10D, 16'h23A5, 16'h0F5A, 16'h0FAB, 16'hFE55};
	localparam logic [53:0] RST_F = {2'b10, 6'h00, 2'h3, 5'h1C, 2'h2, 1'b1, 9'h000, 9'h000, 9'h000, 9'h000};
	localparam logic [53:0] PAT_F = {2'b01, 6'h23, 2'h2, 5'h03, 2'h1, 1'b0, 9'h1A5, 9'h15A, 9'h1AB, 9'h055};

	ifx_ctrl_regs dut_u (
		.REF_CLK                    (clk),
		.RESET                      (rst),
		.SERIAL_CLK                 (sclk),
		.SERIAL_SELECT_N            (sel_n),
		.SERIAL_IN                  (ser_in),
		.SERIAL_OUT                 (ser_out),
		.GAIN_STAGE_ON              (fields[53]),
		.LOWPASS_FILTER_ON          (fields[52]),
		.GAIN_CODE                  (fields[51:46]),
		.AMPLIFIER_CURRENT_SETTING  (fields[45:44]),
		.ENVELOPE_LEVEL_SETTING     (fields[43:39]),
		.ATTENUATION_BIAS_SETTING   (fields[38:37]),
		.IMAGE_SIDEBAND_SELECT      (fields[36]),
		.IN_PHASE_OFFSET_POLARITY   (fields[35]),
		.IN_PHASE_OFFSET_VALUE      (fields[34:27]),
		.QUADRATURE_OFFSET_POLARITY (fields[26]),
		.QUADRATURE_OFFSET_VALUE    (fields[25:18]),
		.IN_PHASE_TRIM              (fields[17:9]),
		.QUADRATURE_TRIM            (fields[8:0])
	);

	ifx_host_model host_u (
		.clk             (clk),
		.serial_out      (ser_out),
		.serial_clk      (sclk),
		.serial_select_n (sel_n),
		.serial_in       (ser_in)
	);

	task automatic check(input logic [53:0] seen, input logic [53:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [4:0] n, input logic [15:0] exp);
		host_u.read_reg(n);
		check({38'h0, host_u.rd_word}, {38'h0, exp});
	endtask

	task automatic do_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Guards against a hang
	initial begin
		repeat (99000) @(posedge clk);
		num_errors++;
		end_of_test();
	end

	initial begin
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check(fields, RST_F);
		for (int i = 0; i < 7; i++)
			rd(adr[i], rst_v[i]);
		$display("test reset values done");
		// Mixer I keeps 0010 and 01 in its reserved fields
		for (int i = 0; i < 7; i++)
			host_u.write_reg(3'h0, adr[i], pat_v[i], 24);
		check(fields, PAT_F);
		for (int i = 0; i < 7; i++)
			rd(adr[i], pat_v[i]);
		$display("test write readback done");
		host_u.write_reg(3'h5, ADDR_GAIN, 16'h0000, 24);
		host_u.write_reg(3'h0, ADDR_GAIN, 16'h0000, 23);
		host_u.write_reg(3'h0, ADDR_GAIN, 16'h0000, 25);
		host_u.write_reg(3'h0, 5'h02, 16'hFFFF, 24);
		check(fields, PAT_F);
		rd(ADDR_GAIN, 16'hC7FF);
		rd(5'h02, 16'h0000);
		rd(5'h1F, 16'h0000);
		$display("test refused frames done");
		do_reset();
		check(fields, RST_F);
		rd(ADDR_MIX_Q, 16'hF000);
		rd(ADDR_TRIM_I, 16'hF000);
		$display("test second reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
